// >>> design/ldsl_defines.vh
// Constants of the loop detector status logic: register map, fields, resets, counts
// Assumes inclusion by bare name from the design files
`ifndef LDSL_DEFINES_VH
`define LDSL_DEFINES_VH

// Register byte offsets
`define LDSL_CTRL_ADDR 8'h00
`define LDSL_STATUS_ADDR 8'h04
`define LDSL_MEAS_ADDR 8'h08
`define LDSL_BASE_ADDR 8'h0C
`define LDSL_FAILCNT_ADDR 8'h10
`define LDSL_IRQ_STAT_ADDR 8'h14
`define LDSL_IRQ_EN_ADDR 8'h18
`define LDSL_IRQ_CLR_ADDR 8'h1C
`define LDSL_NVM_ADDR 8'h20

// Control fields
`define LDSL_CTRL_SENS_LSB 0
`define LDSL_CTRL_FREQ_LSB 4
`define LDSL_CTRL_PROG_BIT 8
`define LDSL_CTRL_STEP_UP_BIT 9
`define LDSL_CTRL_STEP_DN_BIT 10
`define LDSL_CTRL_SAVE_BIT 11

// Sensitivity codes: 0..8 levels, then forced call, then channel off
`define LDSL_SENS_LEVELS 4'h9
`define LDSL_SENS_CALL 4'h9
`define LDSL_SENS_OFF 4'hA
`define LDSL_SENS_MAX 4'h8

// Reset values of stored settings
`define LDSL_SENS_RESET 4'h4
`define LDSL_FREQ_RESET 3'h0

// Fault codes shown on the status register
`define LDSL_CODE_NONE 2'h0
`define LDSL_CODE_LOW 2'h1
`define LDSL_CODE_HIGH 2'h2

// Interrupt bits
`define LDSL_IRQ_LOW_BIT 0
`define LDSL_IRQ_HIGH_BIT 1
`define LDSL_IRQ_CALL_BIT 2

// Fault limit is one quarter of the baseline (shift by two)
`define LDSL_FAULT_SHIFT 2
// Threshold at the least sensitive level is baseline shifted right by this
`define LDSL_THRESH_BASE_SHIFT 3

`endif

// >>> design/ldsl_loop_status.v
// Status and fault logic of a single-channel inductive loop detector, AXI4-Lite slave
// Assumes a measured loop period count, a phase green pin and a 250 MHz clock
//
// Overview of operation
// - Call output decided from processed loop measurement and phase green input
// - Bargraph has exactly eight segments showing relative inductance change
// - First segment lights when change reaches call threshold at selected level
// - Each further level whose threshold is met lights one more segment
// - Settings kept in non-volatile store, changed only by explicit programming
// - Inductance fall of 25 percent or shorted loop gives low failure code
// - Inductance rise of 25 percent or open loop gives high failure code
// - Failure counter increments once per low or high failure event
// - Failure counter cleared by detector reset or power loss
// - Program mode shows live loop oscillator frequency reading
// - Eight loop frequency settings, stepped up or down one at a time
// - Nine sensitivity levels, each step doubles or halves sensitivity
// - Forced call holds call output and disables the oscillator
// - Channel off holds no call and disables the oscillator
`timescale 1ns/1ps
`include "ldsl_defines.vh"
module ldsl_loop_status #(
    parameter MW = 16,
    parameter CW = 8,
    parameter GREEN_BOOST = 1
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Loop measurement
    input wire [MW-1:0] loopCount,
    input wire loopCountValid,
    input wire loopShort,
    input wire loopOpen,
    input wire phaseGreen,
    // Detector outputs
    output reg callOut,
    output reg oscEnable,
    output reg [2:0] freqSelect,
    output reg [7:0] bargraph,
    output reg irq,
    // AXI4-Lite write address
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);
    // Load states for settings out of the store after reset
    localparam LD_ADDR = 3'b001;
    localparam LD_WAIT = 3'b010;
    localparam LD_RUN = 3'b100;

    reg [2:0] loadState;
    reg [3:0] sens;
    reg progMode;
    reg [MW-1:0] baseline;
    reg baseValid;
    reg [MW-1:0] liveCount;
    reg [1:0] faultCode;
    reg [CW-1:0] failCount;
    reg [2:0] irqStat;
    reg [2:0] irqEn;
    reg detect;
    reg [2:0] shortSync;
    reg [2:0] openSync;
    reg [2:0] greenSync;
    reg shortLvl;
    reg openLvl;
    reg greenLvl;
    reg [7:0] awAddr;
    reg awHeld;
    reg [31:0] wData;
    reg [3:0] wStrb;
    reg wHeld;
    reg nvmWr;
    reg [7:0] nvmData;
    wire [7:0] nvmRd;
    wire forcedMode;
    wire [MW-1:0] lowLimit;
    wire [MW-1:0] highLimit;
    wire lowFault;
    wire highFault;
    wire [MW-1:0] delta;
    wire [MW-1:0] quarter;
    wire [1:0] next_faultCode;
    wire newFault;
    wire [7:0] next_bargraph;
    wire wrFire;

    // Settings in the store: sensitivity in bits 3:0, frequency in bits 6:4
    ldsl_settings_store #(
        .WIDTH(8),
        .DEPTH(4),
        .AW(2)
    ) settingsStore (
        .clk(clk),
        .wrEn(nvmWr),
        .wrAddr(2'h0),
        .wrData(nvmData),
        .rdAddr(2'h0),
        .rdData(nvmRd)
    );

    // Pin synchronisers, level changes once stages two and three agree
    always @(posedge clk) begin
        if (rst) begin
            shortSync <= 3'h0;
            openSync <= 3'h0;
            greenSync <= 3'h0;
            shortLvl <= 1'b0;
            openLvl <= 1'b0;
            greenLvl <= 1'b0;
        end else begin
            shortSync <= {shortSync[1:0], loopShort};
            openSync <= {openSync[1:0], loopOpen};
            greenSync <= {greenSync[1:0], phaseGreen};
            if (shortSync[1] == shortSync[2]) shortLvl <= shortSync[2];
            if (openSync[1] == openSync[2]) openLvl <= openSync[2];
            if (greenSync[1] == greenSync[2]) greenLvl <= greenSync[2];
        end
    end

    assign forcedMode = (sens == `LDSL_SENS_CALL) || (sens == `LDSL_SENS_OFF);

    // low limit / high limit at one quarter of the baseline
    assign quarter = baseline >> `LDSL_FAULT_SHIFT;
    assign lowLimit = baseline - quarter;
    assign highLimit = baseline + quarter;
    // Larger inductance gives a longer period count, so count tracks inductance
    assign lowFault = shortLvl || (baseValid && liveCount <= lowLimit);
    assign highFault = openLvl || (baseValid && liveCount >= highLimit);
    assign next_faultCode = forcedMode ? `LDSL_CODE_NONE :
                            lowFault ? `LDSL_CODE_LOW :
                            highFault ? `LDSL_CODE_HIGH : `LDSL_CODE_NONE;
    assign newFault = (next_faultCode != `LDSL_CODE_NONE) && (faultCode == `LDSL_CODE_NONE);

    // Vehicle presence lowers inductance: change is baseline minus live count
    assign delta = (baseValid && liveCount < baseline) ? (baseline - liveCount) : {MW{1'b0}};

    // eight segments, first at call threshold, one per further level
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : segGen
            // each level halves the threshold; segment g needs level sens minus g
            localparam [4:0] SEG = g;
            wire [4:0] lvl = {1'b0, sens} - SEG;
            wire [MW-1:0] thr = (baseline >> `LDSL_THRESH_BASE_SHIFT) >> lvl[3:0];
            assign next_bargraph[g] = !forcedMode && !lvl[4] && baseValid &&
                                      (faultCode == `LDSL_CODE_NONE) && (delta >= thr);
        end
    endgenerate

    // Settings load after reset, then measurement, faults and call output
    always @(posedge clk) begin
        if (rst) begin
            loadState <= LD_ADDR;
            sens <= `LDSL_SENS_RESET;
            freqSelect <= `LDSL_FREQ_RESET;
            baseline <= {MW{1'b0}};
            baseValid <= 1'b0;
            liveCount <= {MW{1'b0}};
            faultCode <= `LDSL_CODE_NONE;
            failCount <= {CW{1'b0}};
            detect <= 1'b0;
            callOut <= 1'b0;
            oscEnable <= 1'b0;
            bargraph <= 8'h00;
        end else begin
            case (loadState)
                LD_ADDR: loadState <= LD_WAIT;
                LD_WAIT: begin
                    // settings come back from the store, not from reset
                    if (nvmRd[3:0] <= `LDSL_SENS_OFF) sens <= nvmRd[3:0];
                    freqSelect <= nvmRd[6:4];
                    loadState <= LD_RUN;
                end
                LD_RUN: begin
                    if (nvmWr) begin
                        sens <= nvmData[3:0];
                        freqSelect <= nvmData[6:4];
                    end
                end
                default: loadState <= LD_ADDR;
            endcase
            if (nvmWr) begin
                // New tuning needs a new baseline
                baseValid <= 1'b0;
            end else if (loopCountValid && !forcedMode) begin
                liveCount <= loopCount;
                if (!baseValid) begin
                    baseline <= loopCount;
                    baseValid <= 1'b1;
                end
            end
            faultCode <= next_faultCode;
            // count once per event / saturate
            if (newFault && failCount != {CW{1'b1}}) begin
                failCount <= failCount + 1'b1;
            end
            bargraph <= next_bargraph;
            detect <= next_bargraph[0];
            oscEnable <= (loadState == LD_RUN) && !forcedMode;
            // call from measurement and phase green; override
            if (sens == `LDSL_SENS_CALL) begin
                callOut <= 1'b1;
            end else if (sens == `LDSL_SENS_OFF) begin
                callOut <= 1'b0;
            end else begin
                // Failure forces a call for safety; during green, hold a placed call while delta is nonzero
                callOut <= (faultCode != `LDSL_CODE_NONE) || next_bargraph[0] ||
                           (GREEN_BOOST != 0 && greenLvl && callOut && delta != 0);
            end
        end
    end

    // AXI4-Lite write channel: take address and data in either order
    assign wrFire = awHeld && wHeld && !s_axi_bvalid;
    always @(posedge clk) begin
        if (rst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddr <= 8'h00;
            wData <= 32'h0000_0000;
            wStrb <= 4'h0;
            progMode <= 1'b0;
            irqEn <= 3'h0;
            nvmWr <= 1'b0;
            nvmData <= 8'h00;
        end else begin
            nvmWr <= 1'b0;
            if (s_axi_awvalid && s_axi_awready) begin
                awAddr <= s_axi_awaddr;
                awHeld <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
                wHeld <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
            if (wrFire) begin
                awHeld <= 1'b0;
                wHeld <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= 2'h0;
                case (awAddr)
                    `LDSL_CTRL_ADDR: begin
                        if (wStrb[1]) progMode <= wData[`LDSL_CTRL_PROG_BIT];
                        // only explicit programming writes the store
                        if (wStrb[1] && wData[`LDSL_CTRL_SAVE_BIT] && loadState == LD_RUN) begin
                            nvmWr <= 1'b1;
                            nvmData <= {1'b0, wData[`LDSL_CTRL_FREQ_LSB +: 3],
                                        (wData[3:0] > `LDSL_SENS_OFF) ? sens : wData[3:0]};
                        end else if (wStrb[1] && loadState == LD_RUN &&
                                     (wData[`LDSL_CTRL_STEP_UP_BIT] ||
                                      wData[`LDSL_CTRL_STEP_DN_BIT])) begin
                            // step frequency one setting at a time, saturating
                            nvmWr <= 1'b1;
                            nvmData <= {1'b0,
                                (wData[`LDSL_CTRL_STEP_UP_BIT] && freqSelect != 3'h7) ?
                                    freqSelect + 3'h1 :
                                (wData[`LDSL_CTRL_STEP_DN_BIT] && !wData[`LDSL_CTRL_STEP_UP_BIT]
                                    && freqSelect != 3'h0) ? freqSelect - 3'h1 : freqSelect,
                                sens};
                        end
                    end
                    `LDSL_IRQ_EN_ADDR: if (wStrb[0]) irqEn <= wData[2:0];
                    `LDSL_IRQ_CLR_ADDR: ;
                    `LDSL_STATUS_ADDR, `LDSL_MEAS_ADDR, `LDSL_BASE_ADDR,
                    `LDSL_FAILCNT_ADDR, `LDSL_IRQ_STAT_ADDR, `LDSL_NVM_ADDR: ;
                    default: s_axi_bresp <= 2'h2;
                endcase
            end
        end
    end

    // Sticky interrupt status: events set, write-one clears, set wins
    always @(posedge clk) begin
        if (rst) begin
            irqStat <= 3'h0;
            irq <= 1'b0;
        end else begin
            irqStat <= (irqStat & ~((wrFire && awAddr == `LDSL_IRQ_CLR_ADDR && wStrb[0]) ?
                        wData[2:0] : 3'h0)) |
                       {next_bargraph[0] && !detect,
                        newFault && next_faultCode == `LDSL_CODE_HIGH,
                        newFault && next_faultCode == `LDSL_CODE_LOW};
            irq <= |(irqStat & irqEn);
        end
    end

    // AXI4-Lite read channel, one read at a time
    always @(posedge clk) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else begin
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'h0;
                case (s_axi_araddr)
                    `LDSL_CTRL_ADDR:
                        s_axi_rdata <= {23'h0, progMode, 1'b0, freqSelect, sens};
                    `LDSL_STATUS_ADDR:
                        s_axi_rdata <= {20'h0, callOut, oscEnable, faultCode, bargraph};
                    // live frequency reading only in program mode
                    `LDSL_MEAS_ADDR:
                        s_axi_rdata <= progMode ? {{(32-MW){1'b0}}, liveCount} : 32'h0000_0000;
                    `LDSL_BASE_ADDR:
                        s_axi_rdata <= {{(31-MW){1'b0}}, baseValid, baseline};
                    `LDSL_FAILCNT_ADDR: s_axi_rdata <= {{(32-CW){1'b0}}, failCount};
                    `LDSL_IRQ_STAT_ADDR: s_axi_rdata <= {29'h0, irqStat};
                    `LDSL_IRQ_EN_ADDR: s_axi_rdata <= {29'h0, irqEn};
                    `LDSL_IRQ_CLR_ADDR: s_axi_rdata <= 32'h0000_0000;
                    `LDSL_NVM_ADDR: s_axi_rdata <= {24'h0, nvmRd};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= 2'h2;
                    end
                endcase
            end
        end
    end
endmodule

// >>> design/ldsl_settings_store.v
// Non-volatile settings store: a small register array standing in for the memory
// Assumes that only explicit writes change it; rst is deliberately not used on the cells
`timescale 1ns/1ps
module ldsl_settings_store #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    // Clock
    input wire clk,
    // Write port
    input wire wrEn,
    input wire [AW-1:0] wrAddr,
    input wire [WIDTH-1:0] wrData,
    // Read port
    input wire [AW-1:0] rdAddr,
    output reg [WIDTH-1:0] rdData
);
    reg [WIDTH-1:0] cells [0:DEPTH-1];

    // Write on explicit request only, registered read
    always @(posedge clk) begin
        if (wrEn) begin
            cells[wrAddr] <= wrData;
        end
        rdData <= cells[rdAddr];
    end
endmodule

// >>> verification/ldsl_loop_model.sv
// Loop oscillator and controller pins seen by the detector
// Assumes the bench sets the wanted count and pin levels on the test inputs
`timescale 1ns/1ps
module ldsl_loop_model (
    // Clock
    input wire clk,
    // Bench controls
    input wire [15:0] countIn,
    input wire shortIn,
    input wire openIn,
    input wire greenIn,
    // Oscillator enable from the detector
    input wire oscEnable,
    // Measurement and pins toward the detector
    output reg [15:0] loopCount = 16'h0000,
    output reg loopCountValid = 1'b0,
    output reg loopShort = 1'b0,
    output reg loopOpen = 1'b0,
    output reg phaseGreen = 1'b0
);
    reg [1:0] phase = 2'h0;

    // One count every fourth cycle while running; a stopped oscillator gives garbage
    always @(posedge clk) begin
        phase <= phase + 2'h1;
        loopShort <= shortIn;
        loopOpen <= openIn;
        phaseGreen <= greenIn;
        loopCountValid <= oscEnable && phase == 2'h3;
        if (!oscEnable) begin
            loopCount <= ~loopCount;
        end else if (phase == 2'h3) begin
            loopCount <= countIn;
        end
    end
endmodule

// >>> verification/ldsl_loop_status_monitor.sv
// Port checker of the loop status block: bargraph shape, call and bus handshakes
// Assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module ldsl_loop_status_monitor (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Detector outputs
    input wire callOut,
    input wire oscEnable,
    input wire [7:0] bargraph,
    // Write channels
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    // Read channels
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Write taken on both channels, then answered
    sequence wTaken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence bAnswer;
        ##[1:2] s_axi_bvalid;
    endsequence

    chk_bar_prefix: assert property ((bargraph & (bargraph + 8'h01)) == 8'h00)
        else $error("bargraph segments not contiguous");
    chk_bar_call: assert property (bargraph[0] && oscEnable |-> ##[0:2] (callOut || !oscEnable))
        else $error("first segment without call");
    chk_write_answer: assert property (wTaken |-> bAnswer)
        else $error("write not answered");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    chk_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while answering");
    chk_unmapped_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0000_0000)
        else $error("error read with data");
endmodule

bind ldsl_loop_status ldsl_loop_status_monitor mon_u (.clk(clk), .rst(rst), .callOut(callOut),
    .oscEnable(oscEnable), .bargraph(bargraph), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// >>> verification/ldsl_loop_status_test.sv
// Bench of the loop status block: bus tasks, loop model, one task per scenario
// Assumes the design, its defines header, the loop model and the monitor are compiled
`timescale 1ns/1ps
`include "ldsl_defines.vh"
module ldsl_loop_status_test;
    localparam [15:0] BASE = 16'h1000;
    reg clk = 1'b0, rst = 1'b1, awValid = 1'b0, wValid = 1'b0, bReady = 1'b0;
    reg arValid = 1'b0, rReady = 1'b0, shortIn = 1'b0, openIn = 1'b0, greenIn = 1'b0;
    reg [7:0] awAddr = 8'h00, arAddr = 8'h00;
    reg [31:0] wData = 32'h0000_0000, rdWord;
    reg [15:0] count = BASE;
    integer errCount = 0, nTests = 0, cycles = 0;
    wire [15:0] loopCount;
    wire loopCountValid, loopShort, loopOpen, phaseGreen, callOut, oscEnable, irq;
    wire awReady, wReady, bValid, arReady, rValid;
    wire [2:0] freqSelect;
    wire [7:0] bargraph;
    wire [1:0] bResp, rResp;
    wire [31:0] rData;

    // Detector and its loop side
    ldsl_loop_status dut_u (.clk(clk), .rst(rst), .loopCount(loopCount),
        .loopCountValid(loopCountValid), .loopShort(loopShort), .loopOpen(loopOpen),
        .phaseGreen(phaseGreen), .callOut(callOut), .oscEnable(oscEnable),
        .freqSelect(freqSelect), .bargraph(bargraph), .irq(irq),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
        .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady));
    ldsl_loop_model model_u (.clk(clk), .countIn(count), .shortIn(shortIn), .openIn(openIn),
        .greenIn(greenIn), .oscEnable(oscEnable), .loopCount(loopCount),
        .loopCountValid(loopCountValid), .loopShort(loopShort), .loopOpen(loopOpen),
        .phaseGreen(phaseGreen));

    // 250 MHz clock and a cycle ceiling against hangs
    always #2 clk = ~clk;
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles > 20000) begin
            errCount = errCount + 1;
            tallyAndFinish;
        end
    end

    task tick(input integer n);
        repeat (n) @(posedge clk);
    endtask

    task check(input [31:0] got, input [31:0] exp);
        nTests = nTests + 1;
        if (got !== exp) begin
            errCount = errCount + 1;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Write one word, each channel released when taken
    task axiWr(input [7:0] a, input [31:0] d, input [1:0] expResp);
        reg awDone, wDone;
        begin
            awAddr <= a;
            wData <= d;
            awValid <= 1'b1;
            wValid <= 1'b1;
            bReady <= 1'b1;
            awDone = 1'b0;
            wDone = 1'b0;
            while (!(awDone && wDone)) begin
                @(posedge clk);
                if (!awDone && awReady === 1'b1) begin
                    awDone = 1'b1;
                    awValid <= 1'b0;
                end
                if (!wDone && wReady === 1'b1) begin
                    wDone = 1'b1;
                    wValid <= 1'b0;
                end
            end
            while (bValid !== 1'b1) @(posedge clk);
            check(bResp, expResp);
            bReady <= 1'b0;
            @(posedge clk);
        end
    endtask

    // Read one word into rdWord
    task axiRd(input [7:0] a, input [1:0] expResp);
        begin
            arAddr <= a;
            arValid <= 1'b1;
            rReady <= 1'b1;
            do @(posedge clk); while (arReady !== 1'b1);
            arValid <= 1'b0;
            while (rValid !== 1'b1) @(posedge clk);
            rdWord = rData;
            check(rResp, expResp);
            rReady <= 1'b0;
            @(posedge clk);
        end
    endtask

    // Save sensitivity and frequency with the loop vacant
    task setSens(input [3:0] s, input [2:0] f);
        count <= BASE;
        tick(8);
        axiWr(`LDSL_CTRL_ADDR, {20'h0_0000, 1'b1, 3'b000, 1'b0, f, s}, 2'b00);
        tick(16);
    endtask

    task barCase(input [3:0] s, input [15:0] delta, input [7:0] exp);
        setSens(s, 3'h0);
        count <= BASE - delta;
        tick(16);
        check(bargraph, exp);
        check(callOut, exp != 8'h00);
    endtask

    task testBar;
        barCase(4'h4, 16'h001F, 8'h00);
        barCase(4'h4, 16'h0020, 8'h01);
        barCase(4'h4, 16'h0080, 8'h07);
        barCase(4'h4, 16'h03E8, 8'h1F);
        barCase(4'h8, 16'h0080, 8'h7F);
        barCase(4'h0, 16'h0200, 8'h01);
    endtask

    task faultCase(input [15:0] c, input sh, input op, input [1:0] code, input [7:0] n);
        count <= c;
        shortIn <= sh;
        openIn <= op;
        tick(16);
        axiRd(`LDSL_STATUS_ADDR, 2'b00);
        check(rdWord[9:8], code);
        axiRd(`LDSL_FAILCNT_ADDR, 2'b00);
        check(rdWord, n);
        count <= BASE;
        shortIn <= 1'b0;
        openIn <= 1'b0;
        tick(16);
        axiRd(`LDSL_STATUS_ADDR, 2'b00);
        check(rdWord[9:8], `LDSL_CODE_NONE);
    endtask

    task testFault;
        setSens(4'h4, 3'h0);
        faultCase(BASE - 16'h0400, 1'b0, 1'b0, `LDSL_CODE_LOW, 8'h01);
        faultCase(BASE + 16'h0400, 1'b0, 1'b0, `LDSL_CODE_HIGH, 8'h02);
        faultCase(BASE, 1'b1, 1'b0, `LDSL_CODE_LOW, 8'h03);
        faultCase(BASE, 1'b0, 1'b1, `LDSL_CODE_HIGH, 8'h04);
    endtask

    // Masked, enabled and cleared interrupt
    task testIrq;
        axiWr(`LDSL_IRQ_CLR_ADDR, 32'h0000_0007, 2'b00);
        axiWr(`LDSL_IRQ_EN_ADDR, 32'h0000_0002, 2'b00);
        count <= BASE - 16'h0400;
        tick(16);
        check(irq, 1'b0);
        axiRd(`LDSL_IRQ_STAT_ADDR, 2'b00);
        check(rdWord[1:0], 2'b01);
        axiWr(`LDSL_IRQ_EN_ADDR, 32'h0000_0001, 2'b00);
        tick(4);
        check(irq, 1'b1);
        count <= BASE;
        tick(16);
        axiWr(`LDSL_IRQ_CLR_ADDR, 32'h0000_0001, 2'b00);
        tick(4);
        check(irq, 1'b0);
    endtask

    task testSat;
        repeat (260) begin
            shortIn <= 1'b1;
            tick(10);
            shortIn <= 1'b0;
            tick(10);
        end
        axiRd(`LDSL_FAILCNT_ADDR, 2'b00);
        check(rdWord, 32'h0000_00FF);
    endtask

    task testForced;
        setSens(`LDSL_SENS_CALL, 3'h0);
        check({callOut, oscEnable}, 2'b10);
        setSens(`LDSL_SENS_OFF, 3'h0);
        count <= BASE - 16'h03E8;
        tick(16);
        check({callOut, oscEnable}, 2'b00);
        setSens(4'h4, 3'h0);
        check(oscEnable, 1'b1);
    endtask

    // Step up, step down, then direct frequency, then live reading
    task testFreq;
        axiWr(`LDSL_CTRL_ADDR, 32'h0000_0204, 2'b00);
        tick(4);
        check(freqSelect, 3'h1);
        axiWr(`LDSL_CTRL_ADDR, 32'h0000_0404, 2'b00);
        tick(4);
        check(freqSelect, 3'h0);
        setSens(4'h4, 3'h7);
        check(freqSelect, 3'h7);
        axiWr(`LDSL_CTRL_ADDR, 32'h0000_0174, 2'b00);
        count <= 16'h0ABC;
        tick(16);
        axiRd(`LDSL_MEAS_ADDR, 2'b00);
        check(rdWord, 32'h0000_0ABC);
        axiWr(`LDSL_CTRL_ADDR, 32'h0000_0074, 2'b00);
        axiRd(`LDSL_MEAS_ADDR, 2'b00);
        check(rdWord, 32'h0000_0000);
    endtask

    // Settings survive reset, failures do not; unmapped place refused
    task testKeep;
        setSens(4'h6, 3'h3);
        rst <= 1'b1;
        tick(4);
        rst <= 1'b0;
        tick(8);
        axiRd(`LDSL_CTRL_ADDR, 2'b00);
        check(rdWord, 32'h0000_0036);
        check(freqSelect, 3'h3);
        axiRd(`LDSL_FAILCNT_ADDR, 2'b00);
        check(rdWord, 32'h0000_0000);
        axiWr(8'h40, 32'h0000_0001, 2'b10);
        axiRd(8'h40, 2'b10);
        check(rdWord, 32'h0000_0000);
    endtask

    task tallyAndFinish;
        $display("checks %0d mismatches %0d", nTests, errCount);
        if (errCount == 0 && nTests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Reset for four cycles, then the scenarios
    initial begin
        tick(4);
        rst <= 1'b0;
        tick(4);
        testBar;
        testFault;
        testIrq;
        testSat;
        testForced;
        testFreq;
        testKeep;
        tallyAndFinish;
    end
endmodule
